// >>> core/uaw_pkg.sv
package uaw_pkg;

  // -------------------------------------------------------------------
  // bus geometry and register offsets
  // -------------------------------------------------------------------
  localparam int          WB_ADDR_W    = 4;
  localparam int          WB_DATA_W    = 32;
  localparam int          WB_SEL_W     = WB_DATA_W / 8;
  localparam logic [3:0]  OFS_CTRL     = 4'h0;   // control, read/write
  localparam logic [3:0]  OFS_STATUS   = 4'h4;   // status, read only
  localparam logic [3:0]  OFS_DATA     = 4'h8;   // receive data, read pops

  // -------------------------------------------------------------------
  // word and field layout
  // -------------------------------------------------------------------
  localparam int          RX_WORD_W    = 9;
  localparam int          RX_DEPTH     = 2;
  localparam int          CTRL_W       = 9;
  localparam int          STAT_W       = 5;
  localparam int          TOP9_POS     = 8;      // top bit for 9-bit words
  localparam int          TOP8_POS     = 7;      // top bit for 8-bit words
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          WAKE_SETTLE_NS = 64;
  localparam int          WAKE_SETTLE_CYC =
    (WAKE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef struct packed {
    logic parity_enable;
    logic ninth_bit_select;
    logic receiver_enable;
    logic serial_unit_enable;
    logic wake_enable;
    logic addr_match_enable;
    logic rx_irq_enable;
    logic tx_idle_ie;
    logic tx_empty_ie;
  } uaw_ctrl_t;

  typedef struct packed {
    logic wake_busy;
    logic overrun_flag;
    logic rx_avail_flag;
    logic tx_idle;
    logic tx_empty;
  } uaw_status_t;

  typedef enum logic [3:0] {
    WK_IDLE    = 4'b0001,
    WK_ARMED   = 4'b0010,
    WK_WAITCLK = 4'b0100,
    WK_SETTLE  = 4'b1000
  } uaw_wake_t;

endpackage : uaw_pkg

// >>> core/uaw_edge.sv
`timescale 1ns/1ns
module uaw_edge #(
  parameter bit RISING = 1'b1,
  parameter bit INIT   = 1'b0
) (
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  input  wire logic sig_in,
  output logic      pulse_out
);

  logic prev_ff;
  logic nxt_prev;

  // -------------------------------------------------------------------
  // edge detect
  // -------------------------------------------------------------------
  // remember last sample
  always_comb begin
    nxt_prev = sig_in;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prev_ff <= INIT;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  // one-cycle pulse on the chosen edge
  assign pulse_out = RISING ? (sig_in & ~prev_ff) : (~sig_in & prev_ff);

endmodule : uaw_edge

// >>> core/uaw_rxbuf.sv
`timescale 1ns/1ns
module uaw_rxbuf #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  input  wire logic             push_in,
  input  wire logic [WIDTH-1:0] data_in,
  input  wire logic             pop_in,
  output logic      [WIDTH-1:0] head_out,
  output logic                  not_empty_out,
  output logic                  overrun_out
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic             do_pop, do_push;

  // -------------------------------------------------------------------
  // pointer and count update
  // -------------------------------------------------------------------
  // a third word while full is dropped and flagged, stored words kept
  always_comb begin
    do_pop      = pop_in & (cnt_ff != '0);
    do_push     = push_in & ((cnt_ff != FULL_CNT) | do_pop);
    overrun_out = push_in & ~do_push;
    nxt_wr      = wr_ff;
    nxt_rd      = rd_ff;
    nxt_cnt     = cnt_ff;
    if (do_push) begin
      nxt_wr = (wr_ff == LAST_PTR) ? '0 : PTR_W'(wr_ff + 1'b1);
    end
    if (do_pop) begin
      nxt_rd = (rd_ff == LAST_PTR) ? '0 : PTR_W'(rd_ff + 1'b1);
    end
    if (do_push & ~do_pop) begin
      nxt_cnt = CNT_W'(cnt_ff + 1'b1);
    end else if (do_pop & ~do_push) begin
      nxt_cnt = CNT_W'(cnt_ff - 1'b1);
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage, no reset needed on data
  always_ff @(posedge sys_clk_in) begin
    if (do_push) begin
      mem_ff[wr_ff] <= data_in;
    end
  end

  assign head_out      = mem_ff[rd_ff];
  assign not_empty_out = (cnt_ff != '0);

endmodule : uaw_rxbuf

// >>> core/uaw_top.sv
`timescale 1ns/1ns
module uaw_top #(
  parameter int SETTLE_CYCLES = uaw_pkg::WAKE_SETTLE_CYC
) (
  input  wire logic                          sys_clk_in,
  input  wire logic                          reset_in,
  input  wire logic                          wb_cyc_in,
  input  wire logic                          wb_stb_in,
  input  wire logic                          wb_we_in,
  input  wire logic [uaw_pkg::WB_ADDR_W-1:0] wb_adr_in,
  input  wire logic [uaw_pkg::WB_SEL_W-1:0]  wb_sel_in,
  input  wire logic [uaw_pkg::WB_DATA_W-1:0] wb_dat_in,
  output logic      [uaw_pkg::WB_DATA_W-1:0] wb_dat_out,
  output logic                               wb_ack_out,
  input  wire logic                          unit_clk_on_in,
  input  wire logic                          low_power_in,
  input  wire logic                          rx_pin_in,
  input  wire logic                          rx_word_valid_in,
  input  wire logic [uaw_pkg::RX_WORD_W-1:0] rx_word_in,
  input  wire logic                          tx_empty_in,
  input  wire logic                          tx_idle_in,
  input  wire logic                          global_irq_enable_in,
  input  wire logic                          serial_irq_enable_in,
  input  wire logic                          stack_full_in,
  input  wire logic                          irq_taken_in,
  output logic                               irq_n_out,
  output logic                               service_req_out,
  output logic                               wake_out,
  output logic                               datapath_hold_out,
  output uaw_pkg::uaw_ctrl_t                 ctrl_out
);
  import uaw_pkg::*;

  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYCLES - 1);

  // -------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------
  uaw_ctrl_t                ctrl_ff, nxt_ctrl;
  logic                     ack_ff, nxt_ack;
  logic [WB_DATA_W-1:0]     rdat_ff, nxt_rdat;
  logic                     seen_ff, nxt_seen;
  logic                     ovr_flag_ff, nxt_ovr_flag;
  logic                     irq_n_ff, nxt_irq_n;
  logic                     pend_ff, nxt_pend;
  logic                     svc_ff, nxt_svc;
  logic                     hold_ff, nxt_hold;
  logic                     wake_ff, nxt_wake;
  uaw_wake_t                wst_ff, nxt_wst;
  logic [CNT_W-1:0]         cnt_ff, nxt_cnt;
  uaw_status_t              status;
  logic                     req, rd_status, rd_data;
  logic                     rx_fall, txe_ev, txi_ev;
  logic                     rx_push, rx_top, rx_ev, ovr_pulse, ovr_ev;
  logic                     avail, wake_ok, wake_done, wake_fire, ev_any;
  logic [RX_WORD_W-1:0]     head;

  // -------------------------------------------------------------------
  // edge detectors and receive buffer
  // -------------------------------------------------------------------
  // rx pin idles high; runs on the free clock, not the unit clock
  uaw_edge #(.RISING(1'b0), .INIT(1'b1)) u_rx_fall (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .sig_in     (rx_pin_in),
    .pulse_out  (rx_fall)
  );

  // enabling while the condition stands also raises a pulse
  uaw_edge #(.RISING(1'b1), .INIT(1'b0)) u_txe (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .sig_in     (tx_empty_in & ctrl_ff.tx_empty_ie),
    .pulse_out  (txe_ev)
  );

  uaw_edge #(.RISING(1'b1), .INIT(1'b0)) u_txi (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .sig_in     (tx_idle_in & ctrl_ff.tx_idle_ie),
    .pulse_out  (txi_ev)
  );

  uaw_rxbuf #(.WIDTH(RX_WORD_W), .DEPTH(RX_DEPTH)) u_rxbuf (
    .sys_clk_in    (sys_clk_in),
    .reset_in      (reset_in),
    .push_in       (rx_push),
    .data_in       (rx_word_in),
    .pop_in        (rd_data),
    .head_out      (head),
    .not_empty_out (avail),
    .overrun_out   (ovr_pulse)
  );

  // -------------------------------------------------------------------
  // source qualification
  // -------------------------------------------------------------------
  // words are dropped while waking or held
  always_comb begin
    rx_push   = rx_word_valid_in & ctrl_ff.receiver_enable & (wst_ff == WK_IDLE)
                & ~hold_ff;
    rx_top    = ctrl_ff.ninth_bit_select ? rx_word_in[TOP9_POS]
                                         : rx_word_in[TOP8_POS];
    rx_ev     = rx_push & ctrl_ff.rx_irq_enable
                & (~ctrl_ff.addr_match_enable | rx_top);
    ovr_ev    = ovr_pulse & ctrl_ff.rx_irq_enable;
    wake_ok   = ctrl_ff.wake_enable & ctrl_ff.serial_unit_enable
                & ctrl_ff.receiver_enable & ctrl_ff.rx_irq_enable;
    wake_done = (wst_ff == WK_SETTLE) & (cnt_ff == '0);
    wake_fire = wake_done & global_irq_enable_in & serial_irq_enable_in;
    ev_any    = txe_ev | txi_ev | rx_ev | ovr_ev | wake_fire;
  end

  // -------------------------------------------------------------------
  // bus decode and register file
  // -------------------------------------------------------------------
  // ack one cycle after the request, dropped the cycle after
  always_comb begin
    req       = wb_cyc_in & wb_stb_in & ~ack_ff;
    rd_status = req & ~wb_we_in & (wb_adr_in == OFS_STATUS);
    rd_data   = req & ~wb_we_in & (wb_adr_in == OFS_DATA);
    status    = '{wake_busy: (wst_ff != WK_IDLE), overrun_flag: ovr_flag_ff,
                  rx_avail_flag: avail, tx_idle: tx_idle_in, tx_empty: tx_empty_in};
    nxt_ack   = req;
    nxt_rdat  = rdat_ff;
    nxt_ctrl  = ctrl_ff;
    if (req & ~wb_we_in) begin
      unique case (wb_adr_in)
        OFS_CTRL:   nxt_rdat = WB_DATA_W'(ctrl_ff);
        OFS_STATUS: nxt_rdat = WB_DATA_W'(status);
        OFS_DATA:   nxt_rdat = avail ? WB_DATA_W'(head) : '0;
        default:    nxt_rdat = '0;
      endcase
    end
    // only bus writes touch control; low power never does
    if (req & wb_we_in & (wb_adr_in == OFS_CTRL)) begin
      if (wb_sel_in[0]) begin
        nxt_ctrl[7:0] = wb_dat_in[7:0];
      end
      if (wb_sel_in[1]) begin
        nxt_ctrl[CTRL_W-1:8] = wb_dat_in[CTRL_W-1:8];
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_ff  <= 1'b0;
      rdat_ff <= '0;
      ctrl_ff <= CTRL_RST;
    end else begin
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
      ctrl_ff <= nxt_ctrl;
    end
  end

  // -------------------------------------------------------------------
  // overrun flag, cleared by status read then data read
  // -------------------------------------------------------------------
  // software cannot write it; a new overrun beats the clear
  always_comb begin
    nxt_seen     = seen_ff;
    nxt_ovr_flag = ovr_flag_ff;
    if (rd_status) begin
      nxt_seen = 1'b1;
    end else if (rd_data) begin
      nxt_seen = 1'b0;
    end
    if (rd_data & seen_ff) begin
      nxt_ovr_flag = 1'b0;
    end
    if (ovr_pulse) begin
      nxt_ovr_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      seen_ff     <= 1'b0;
      ovr_flag_ff <= 1'b0;
    end else begin
      seen_ff     <= nxt_seen;
      ovr_flag_ff <= nxt_ovr_flag;
    end
  end

  // -------------------------------------------------------------------
  // wake sequencer
  // -------------------------------------------------------------------
  always_comb begin
    nxt_wst  = wst_ff;
    nxt_cnt  = cnt_ff;
    nxt_wake = 1'b0;
    unique case (wst_ff)
      WK_IDLE: begin
        if (~unit_clk_on_in) begin
          nxt_wst = WK_ARMED;
        end
      end
      WK_ARMED: begin
        if (unit_clk_on_in) begin
          nxt_wst = WK_IDLE;
        end else if (wake_ok & rx_fall) begin
          nxt_wst  = WK_WAITCLK;
          nxt_wake = 1'b1;
        end
      end
      WK_WAITCLK: begin
        if (unit_clk_on_in) begin
          nxt_wst = WK_SETTLE;
          nxt_cnt = SETTLE_LOAD;
        end
      end
      WK_SETTLE: begin
        if (cnt_ff == '0) begin
          nxt_wst = WK_IDLE;
        end else begin
          nxt_cnt = CNT_W'(cnt_ff - 1'b1);
        end
      end
      default: begin
        nxt_wst = WK_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wst_ff  <= WK_IDLE;
      cnt_ff  <= '0;
      wake_ff <= 1'b0;
    end else begin
      wst_ff  <= nxt_wst;
      cnt_ff  <= nxt_cnt;
      wake_ff <= nxt_wake;
    end
  end

  // -------------------------------------------------------------------
  // interrupt pulse, service request, datapath hold
  // -------------------------------------------------------------------
  // new event wins over the taken acknowledge
  always_comb begin
    nxt_irq_n = ~ev_any;
    nxt_pend  = (pend_ff & ~irq_taken_in) | ev_any;
    nxt_svc   = nxt_pend & global_irq_enable_in & serial_irq_enable_in
                & ~stack_full_in;
    nxt_hold  = ~unit_clk_on_in | low_power_in;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_n_ff <= 1'b1;
      pend_ff  <= 1'b0;
      svc_ff   <= 1'b0;
      hold_ff  <= 1'b0;
    end else begin
      irq_n_ff <= nxt_irq_n;
      pend_ff  <= nxt_pend;
      svc_ff   <= nxt_svc;
      hold_ff  <= nxt_hold;
    end
  end

  assign wb_ack_out        = ack_ff;
  assign wb_dat_out        = rdat_ff;
  assign irq_n_out         = irq_n_ff;
  assign service_req_out   = svc_ff;
  assign wake_out          = wake_ff;
  assign datapath_hold_out = hold_ff;
  assign ctrl_out          = ctrl_ff;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  tx_empty_irq_a: assert property ($rose(tx_empty_in & ctrl_ff.tx_empty_ie) |=> !irq_n_out)
    else $error("tx empty did not pulse irq");
  addr_block_a: assert property (rx_push && ctrl_ff.addr_match_enable && !rx_top
      && !txe_ev && !txi_ev && !ovr_ev && !wake_fire |=> irq_n_out)
    else $error("address mode irq on data word");
  addr_pass_a: assert property (rx_push && ctrl_ff.rx_irq_enable && rx_top
      |=> !irq_n_out)
    else $error("address word gave no irq");
  plain_rx_a: assert property (rx_push && ctrl_ff.rx_irq_enable && !ctrl_ff.addr_match_enable
      |=> !irq_n_out)
    else $error("rx word gave no irq");
  avail_flag_a: assert property (rx_push |=> avail)
    else $error("data available not set");
  ovr_irq_a: assert property (ovr_pulse && ctrl_ff.rx_irq_enable |=> !irq_n_out)
    else $error("overrun gave no irq");
  ovr_clear_a: assert property ($fell(ovr_flag_ff) |-> $past(rd_data && seen_ff))
    else $error("overrun flag cleared without read sequence");
  service_a: assert property (service_req_out |-> $past(global_irq_enable_in
      && serial_irq_enable_in && !stack_full_in))
    else $error("service request without enables");
  hold_a: assert property (!unit_clk_on_in |=> datapath_hold_out ##1 datapath_hold_out
      or unit_clk_on_in)
    else $error("datapath not held with clock off");
  wake_pulse_a: assert property (wst_ff == WK_ARMED && !unit_clk_on_in && wake_ok
      && rx_fall |=> wake_out && wst_ff == WK_WAITCLK)
    else $error("falling rx did not wake");
  settle_drop_a: assert property (wst_ff != WK_IDLE |-> !rx_push)
    else $error("rx word taken while waking");
  wake_quiet_a: assert property (wake_done && !(global_irq_enable_in
      && serial_irq_enable_in) |-> !wake_fire)
    else $error("wake irq without enables");
  settle_wait_a: assert property ($rose(wst_ff == WK_SETTLE) |-> !wake_fire)
    else $error("wake irq before settling");

  addr_word_c: cover property (rx_push && ctrl_ff.addr_match_enable && rx_top);
  overrun_c:   cover property (ovr_pulse ##[1:20] (rd_data && seen_ff));
  wake_c:      cover property (wake_out ##[1:200] wake_fire);
  service_c:   cover property (service_req_out ##[1:10] irq_taken_in);

endmodule : uaw_top

// >>> testbench/uaw_rx_partner.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// remote transmitter: receive pin and finished words
// ------------------------------------------------------------------
module uaw_rx_partner (
  input  wire logic                          sys_clk_in,
  output logic                               rx_pin_out,
  output logic                               word_valid_out,
  output logic      [uaw_pkg::RX_WORD_W-1:0] word_out
);
  import uaw_pkg::*;
  // line idles high between frames
  initial begin
    rx_pin_out     = 1'h1;
    word_valid_out = 1'h0;
    word_out       = '0;
  end
  // start bit as a falling edge, back to idle after some cells
  task automatic start_frame(input int cells);
    @(posedge sys_clk_in);
    rx_pin_out <= 1'h0;
    repeat (cells) @(posedge sys_clk_in);
    rx_pin_out <= 1'h1;
  endtask : start_frame
  // one word for one cycle, then a changed value so nothing stale is left
  task automatic send_word(input logic [RX_WORD_W-1:0] w);
    @(posedge sys_clk_in);
    word_out       <= w;
    word_valid_out <= 1'h1;
    @(posedge sys_clk_in);
    word_out       <= ~w;
    word_valid_out <= 1'h0;
  endtask : send_word
endmodule : uaw_rx_partner

// >>> testbench/uart_irq_addr_detect_wakeup_test.sv
`timescale 1ns/1ns
module uart_irq_addr_detect_wakeup_test;
  import uaw_pkg::*;
  localparam int SETTLE = 4;  // shortened settling count
  logic                 clk, rst, cyc, stb, we, ack, irq_n, svc, wake, hold;
  logic                 clk_on, lowp, rx_pin, rx_vld, tx_emp, tx_idl, gie, sie, full, taken;
  logic [WB_ADDR_W-1:0] adr;
  logic [WB_SEL_W-1:0]  sel;
  logic [WB_DATA_W-1:0] wdat, rdat;
  logic [RX_WORD_W-1:0] w, rx_word;
  logic [RX_WORD_W-1:0] ov[3];
  uaw_ctrl_t            ctrl;
  int                   errors, compares, seed;
  logic [31:0]          v, cv, rd_q[$];
  logic [3:0]           sv;
  bit                   irq_q[$], wake_q[$];
  logic [8:0]           tab_c[7] = '{9'h064, 9'h064, 9'h0EC, 9'h0EC, 9'h06C, 9'h06C, 9'h060};
  logic [8:0]           tab_w[7] = '{9'h000, 9'h100, 9'h100, 9'h080, 9'h080, 9'h100, 9'h100};
  bit                   tab_i[7] = '{1, 1, 1, 0, 1, 0, 0};

  uaw_top #(.SETTLE_CYCLES(SETTLE)) dut_u (
    .sys_clk_in(clk), .reset_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .unit_clk_on_in(clk_on), .low_power_in(lowp), .rx_pin_in(rx_pin),
    .rx_word_valid_in(rx_vld), .rx_word_in(rx_word), .tx_empty_in(tx_emp),
    .tx_idle_in(tx_idl), .global_irq_enable_in(gie), .serial_irq_enable_in(sie),
    .stack_full_in(full), .irq_taken_in(taken), .irq_n_out(irq_n), .service_req_out(svc),
    .wake_out(wake), .datapath_hold_out(hold), .ctrl_out(ctrl));
  uaw_rx_partner partner_u (
    .sys_clk_in(clk), .rx_pin_out(rx_pin), .word_valid_out(rx_vld), .word_out(rx_word));

  // ------------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------------
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val
  task automatic chk_flag(input string what, input logic exp, input logic got);
    chk_val(what, {31'h0, exp}, {31'h0, got});
  endtask : chk_flag
  // classic cycle held until ack is sampled high
  task automatic wb(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= wr;
    adr  <= a;
    sel  <= sv;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'h1);
    cyc <= 1'h0;
    stb <= 1'h0;
    we  <= 1'h0;
  endtask : wb
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    wb(1'h0, a, 32'h0);
  endtask : rd
  task automatic drain();
    repeat (4) @(posedge clk);
    chk_val("irq missing", 32'h0, irq_q.size());
    chk_val("wake missing", 32'h0, wake_q.size());
  endtask : drain
  task automatic summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // clock
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end
  // result watcher: each result takes the oldest note
  always @(posedge clk) begin
    if (ack === 1'h1 && cyc === 1'h1 && we === 1'h0 && rd_q.size() > 0)
      chk_val("read data", rd_q.pop_front(), rdat);
    if (irq_n === 1'h0) begin
      chk_flag("irq pulse", 1'h1, irq_q.size() > 0);
      if (irq_q.size() > 0) void'(irq_q.pop_front());
    end
    if (wake === 1'h1) begin
      chk_flag("wake pulse", 1'h1, wake_q.size() > 0);
      if (wake_q.size() > 0) void'(wake_q.pop_front());
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    seed = 32'h46474B6F;
    errors = 0;
    compares = 0;
    rst = 1'h1;
    {cyc, stb, we, adr, sel, wdat} = '0;
    {clk_on, lowp, tx_emp, tx_idl, gie, sie, full, taken} = 8'h8C;  // clock on, enables set
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk_val("ctrl reset", 32'h0, ctrl);
    // random control values and byte lanes, parity kept off in address mode
    sv = 4'hF;
    cv = 32'h0;
    repeat (4) begin
      v = 32'($random(seed)) & 32'h1FF;
      sv = 4'($random(seed));
      v[3] = v[3] & ~cv[8];
      v[8] = v[8] & ~v[3] & ~cv[3];
      cv = {23'h0, sv[1] ? v[8] : cv[8], sv[0] ? v[7:0] : cv[7:0]};
      wb(1'h1, OFS_CTRL, v);
      rd(OFS_CTRL, cv);
    end
    sv = 4'hF;
    wb(1'h1, OFS_STATUS, 32'hFFFFFFFF);
    rd(OFS_STATUS, 32'h0);
    rd(4'hC, 32'h0);
    // receive interrupt against address mode and word length
    for (int i = 0; i < 7; i++) begin
      wb(1'h1, OFS_CTRL, {23'h0, tab_c[i]});
      w = tab_w[i];
      w[6:0] = 7'($random(seed));
      if (tab_i[i]) irq_q.push_back(1'h1);
      partner_u.send_word(w);
      drain();
      rd(OFS_STATUS, 32'h4);
      rd(OFS_DATA, {23'h0, w});
      rd(OFS_STATUS, 32'h0);
    end
    // overrun: three words into two places, then status-data clear
    wb(1'h1, OFS_CTRL, 32'h064);
    for (int i = 0; i < 3; i++) begin
      ov[i] = 9'($random(seed));
      irq_q.push_back(1'h1);
      partner_u.send_word(ov[i]);
    end
    drain();
    rd(OFS_STATUS, 32'hC);
    rd(OFS_DATA, {23'h0, ov[0]});
    rd(OFS_STATUS, 32'h4);
    rd(OFS_DATA, {23'h0, ov[1]});
    rd(OFS_STATUS, 32'h0);
    // transmitter sources with their own enables, then service gating
    wb(1'h1, OFS_CTRL, 32'h001);
    irq_q.push_back(1'h1);
    tx_emp <= ~tx_emp;
    tx_idl <= ~tx_idl;
    drain();
    rd(OFS_STATUS, 32'h3);
    irq_q.push_back(1'h1);
    wb(1'h1, OFS_CTRL, 32'h002);
    drain();
    chk_flag("service", 1'h1, svc);
    full <= ~full;
    repeat (3) @(posedge clk);
    chk_flag("service full", 1'h0, svc);
    full  <= ~full;
    taken <= ~taken;
    @(posedge clk);
    taken <= ~taken;
    tx_emp <= ~tx_emp;
    tx_idl <= ~tx_idl;
    repeat (3) @(posedge clk);
    chk_flag("service taken", 1'h0, svc);
    // low power: datapath held, registers kept, received word dropped
    wb(1'h1, OFS_CTRL, 32'h064);
    lowp <= ~lowp;
    repeat (2) @(posedge clk);
    chk_flag("hold sleep", 1'h1, hold);
    partner_u.send_word(9'h0AA);
    rd(OFS_CTRL, 32'h064);
    lowp <= ~lowp;
    repeat (2) @(posedge clk);
    chk_flag("hold awake", 1'h0, hold);
    rd(OFS_STATUS, 32'h0);
    clk_on <= 1'h0;
    repeat (2) @(posedge clk);
    chk_flag("hold clock off", 1'h1, hold);
    clk_on <= 1'h1;
    // wake-up with and without the processor enables
    for (int g = 1; g >= 0; g--) begin
      wb(1'h1, OFS_CTRL, 32'h074);
      gie <= g[0];
      sie <= g[0] | 1'($random(seed));
      clk_on <= 1'h0;
      repeat (3) @(posedge clk);
      wake_q.push_back(1'h1);
      if (g == 1) irq_q.push_back(1'h1);
      partner_u.start_frame(3);
      partner_u.send_word(9'h055);
      clk_on <= 1'h1;
      repeat (SETTLE - 1) @(posedge clk);
      chk_val("irq early", 32'(g), irq_q.size());
      repeat (SETTLE + 4) @(posedge clk);
      drain();
      rd(OFS_STATUS, 32'h0);
    end
    gie <= 1'h1;
    summarize();
  end
endmodule : uart_irq_addr_detect_wakeup_test
